// ### design/twm_pkg.sv
/*
 * Shared constants for the two-wire memory access block: slave address
 * layout, address latch sizes, bit counts, reset values and the state codes.
 * Assumes nothing of its surroundings; included by the access logic and FIFO.
 */
package twm_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          BYTE_W      = 8;
    localparam int          ADDR_W      = 9;
    localparam int          MEM_DEPTH   = 512;
    localparam int          TYPE_W      = 4;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          FIFO_W      = ADDR_W + BYTE_W;

    // ------------------------------------------------------------
    // Slave address field positions
    // ------------------------------------------------------------
    localparam int          SLV_RW_BIT   = 0;
    localparam int          SLV_PAGE_BIT = 1;
    localparam int          SLV_SEL_LO   = 2;
    localparam int          SLV_SEL_HI   = 3;
    localparam int          SLV_TYPE_LSB = 4;

    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  BIT_LAST     = 4'h8;
    localparam logic [3:0]  BIT_RST      = 4'h0;
    localparam logic [8:0]  ADDR_RST     = 9'h000;
    localparam logic [8:0]  ADDR_TOP     = 9'h1ff;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    // Sync order {cs_high, cs_low, wp, sda, scl}; idle bus lines read high
    localparam logic [4:0]  SYNC_RST     = 5'h03;

    // ------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SLAVE = 5'b00010,
        ST_WORD  = 5'b00100,
        ST_WRITE = 5'b01000,
        ST_READ  = 5'b10000
    } twm_state_type;

endpackage

// ### design/twm_fifo.sv
/*
 * Parameterised valid/ready FIFO carrying address and data of received
 * write bytes from the serial side to the array port.
 * Assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps

module twm_fifo #(
    parameter int WIDTH = twm_pkg::FIFO_W,
    parameter int DEPTH = twm_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import twm_pkg::*;

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = buf_mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next  = count_reg;
        if (push && !pop) begin
            count_next = (PW+1)'(count_reg + 1'b1);
        end else if (pop && !push) begin
            count_next = (PW+1)'(count_reg - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Storage has no reset; only the pointers define content
    always_ff @(posedge clk) begin
        if (push) begin
            buf_mem[wr_ptr_reg] <= in_data;
        end
    end

endmodule

// ### design/twm_access.sv
/*
 * Access logic of a 512-byte serial memory acting as slave on a two-wire
 * bus: start/stop detection, slave address match, 9-bit address latch,
 * writes through a FIFO into the array, sequential reads.
 * Assumes scl, sda and strap pins arrive asynchronously; the bench resolves
 * the open-drain data wire from sda_oe (low drive while high).
 */
`timescale 1ns/1ps

module twm_access #(
    // Device type code; value arbitrary
    parameter logic [twm_pkg::TYPE_W-1:0] DEV_TYPE = 4'h5
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Two-wire bus
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Straps
    input  wire logic chip_select_pin_low,
    input  wire logic chip_select_pin_high,
    input  wire logic write_protect
);
    import twm_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [4:0]          s1_reg, s2_reg, s3_reg;
    logic [4:0]          filt_reg, filt_next;
    logic [1:0]          prev_reg;
    logic                scl_f, sda_f, wp_f;
    logic                scl_rise, scl_fall;
    logic                start_ev, stop_ev;
    logic                match;

    twm_state_type       state_reg, state_next;
    logic [3:0]          bit_cnt_reg, bit_cnt_next;
    logic                ack_ph_reg, ack_ph_next;
    logic                ack_ok_reg, ack_ok_next;
    logic                rw_reg, rw_next;
    logic                page_reg, page_next;
    logic [7:0]          shift_reg, shift_next;
    logic [8:0]          addr_reg, addr_next;
    logic                sda_oe_reg, sda_oe_next;
    logic                inc_ev;
    logic [8:0]          inc_src;

    logic [7:0]          mem [0:MEM_DEPTH-1];
    logic [8:0]          rd_addr;
    logic [7:0]          rd_byte;
    logic                fifo_in_valid, fifo_in_ready;
    logic                fifo_out_valid, fifo_out_ready;
    logic [FIFO_W-1:0]   fifo_out_data;

    function automatic logic [8:0] addr_inc(input logic [8:0] a);
        return 9'(a + 9'h001);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // three-stage filter
    always_comb begin
        filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg   <= SYNC_RST;
            s2_reg   <= SYNC_RST;
            s3_reg   <= SYNC_RST;
            filt_reg <= SYNC_RST;
            prev_reg <= SYNC_RST[1:0];
        end else begin
            s1_reg   <= {chip_select_pin_high, chip_select_pin_low, write_protect, sda_in, scl_in};
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= filt_next;
            prev_reg <= filt_reg[1:0];
        end
    end

    assign scl_f    = filt_reg[0];
    assign sda_f    = filt_reg[1];
    assign wp_f     = filt_reg[2];
    assign scl_rise = scl_f && !prev_reg[0];
    assign scl_fall = !scl_f && prev_reg[0];
    assign start_ev = scl_f && prev_reg[0] && !sda_f && prev_reg[1];
    assign stop_ev  = scl_f && prev_reg[0] && sda_f && !prev_reg[1];

    assign match = (shift_reg[7:SLV_TYPE_LSB] == DEV_TYPE)
                && (shift_reg[SLV_SEL_HI] == filt_reg[4])
                && (shift_reg[SLV_SEL_LO] == filt_reg[3]);

    // page from slave address, low bits from latch
    assign rd_addr = {page_reg, addr_reg[7:0]};
    assign rd_byte = mem[rd_addr];

    // ------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        ack_ph_next   = ack_ph_reg;
        ack_ok_next   = ack_ok_reg;
        rw_next       = rw_reg;
        page_next     = page_reg;
        shift_next    = shift_reg;
        addr_next     = addr_reg;
        sda_oe_next   = sda_oe_reg;
        fifo_in_valid = 1'b0;
        inc_ev        = 1'b0;
        inc_src       = addr_reg;
        if (start_ev) begin
            state_next   = ST_SLAVE;
            bit_cnt_next = BIT_RST;
            ack_ph_next  = 1'b0;
            sda_oe_next  = 1'b0;
        end else if (stop_ev) begin
            state_next   = ST_IDLE;
            ack_ph_next  = 1'b0;
            sda_oe_next  = 1'b0;
        end else begin
            case (state_reg)
                ST_SLAVE, ST_WORD, ST_WRITE: begin
                    if (scl_rise && !ack_ph_reg && bit_cnt_reg != BIT_LAST) begin
                        shift_next   = {shift_reg[6:0], sda_f};
                        bit_cnt_next = 4'(bit_cnt_reg + 1'b1);
                    end else if (scl_fall && !ack_ph_reg && bit_cnt_reg == BIT_LAST) begin
                        ack_ph_next = 1'b1;
                        if (state_reg == ST_SLAVE) begin
                            // no busy period, match always acked
                            if (match) begin
                                sda_oe_next = 1'b1;
                                page_next   = shift_reg[SLV_PAGE_BIT];
                                rw_next     = shift_reg[SLV_RW_BIT];
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else if (state_reg == ST_WORD) begin
                            addr_next   = {page_reg, shift_reg};
                            sda_oe_next = 1'b1;
                        end else if (!wp_f && fifo_in_ready) begin
                            fifo_in_valid = 1'b1;
                            inc_ev        = 1'b1;
                            addr_next     = addr_inc(addr_reg);
                            sda_oe_next   = 1'b1;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end else if (scl_fall && ack_ph_reg) begin
                        ack_ph_next  = 1'b0;
                        bit_cnt_next = BIT_RST;
                        sda_oe_next  = 1'b0;
                        if (state_reg == ST_SLAVE && rw_reg) begin
                            state_next  = ST_READ;
                            shift_next  = rd_byte;
                            sda_oe_next = !rd_byte[7];
                        end else if (state_reg == ST_SLAVE) begin
                            state_next = ST_WORD;
                        end else begin
                            state_next = ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_rise && ack_ph_reg) begin
                        ack_ok_next = !sda_f;
                    end else if (scl_rise) begin
                        bit_cnt_next = 4'(bit_cnt_reg + 1'b1);
                    end else if (scl_fall && !ack_ph_reg && bit_cnt_reg == BIT_LAST) begin
                        // release, count up; page follows a wrap
                        sda_oe_next = 1'b0;
                        ack_ph_next = 1'b1;
                        inc_ev      = 1'b1;
                        inc_src     = rd_addr;
                        addr_next   = addr_inc(rd_addr);
                        page_next   = addr_next[8];
                    end else if (scl_fall && !ack_ph_reg) begin
                        shift_next  = {shift_reg[6:0], 1'b0};
                        sda_oe_next = !shift_reg[6];
                    end else if (scl_fall) begin
                        ack_ph_next  = 1'b0;
                        bit_cnt_next = BIT_RST;
                        if (ack_ok_reg) begin
                            shift_next  = rd_byte;
                            sda_oe_next = !rd_byte[7];
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= BIT_RST;
            ack_ph_reg  <= 1'b0;
            ack_ok_reg  <= 1'b0;
            rw_reg      <= 1'b0;
            page_reg    <= 1'b0;
            shift_reg   <= BYTE_RST;
            addr_reg    <= ADDR_RST;
            sda_oe_reg  <= 1'b0;
            sda_out     <= 1'b0;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            ack_ph_reg  <= ack_ph_next;
            ack_ok_reg  <= ack_ok_next;
            rw_reg      <= rw_next;
            page_reg    <= page_next;
            shift_reg   <= shift_next;
            addr_reg    <= addr_next;
            sda_oe_reg  <= sda_oe_next;
            sda_out     <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_reg;

    // ------------------------------------------------------------
    // Write path and array
    // ------------------------------------------------------------
    // Array port stalls during reads; writes drain long before any read byte
    assign fifo_out_ready = (state_reg != ST_READ);

    twm_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({addr_reg, shift_reg}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clk) begin
        if (fifo_out_valid && fifo_out_ready) begin
            mem[fifo_out_data[FIFO_W-1:BYTE_W]] <= fifo_out_data[BYTE_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence byte_end_s;
        scl_fall && !ack_ph_reg && bit_cnt_reg == BIT_LAST;
    endsequence

    sequence wr_end_s;
        state_reg == ST_WRITE ##0 byte_end_s;
    endsequence

    AST_START_ABORT: assert property (start_ev |=> state_reg == ST_SLAVE
        && bit_cnt_reg == BIT_RST && !sda_oe_reg) else $error("start did not restart");
    AST_STOP_ABORT: assert property (stop_ev |=> state_reg == ST_IDLE
        && !sda_oe_reg) else $error("stop did not abort");
    AST_WRAP: assert property ((inc_ev && inc_src == ADDR_TOP)
        |=> addr_reg == ADDR_RST) else $error("address did not wrap");
    AST_WP_BLOCK: assert property ((wr_end_s ##0 wp_f) |=>
        !sda_oe_reg && $stable(addr_reg) && state_reg == ST_IDLE) else $error("protected write acked");
    AST_WR_ACK: assert property ((wr_end_s ##0 (!wp_f && fifo_in_ready))
        |=> sda_oe_reg && ack_ph_reg) else $error("write byte not acked");
    AST_COMMIT: assert property (fifo_in_valid |=> ##[0:3] !fifo_out_valid)
        else $error("byte not committed before ack");
    AST_RD_RELEASE: assert property ((state_reg == ST_READ ##0 byte_end_s)
        |=> !sda_oe_reg ##1 !sda_oe_reg) else $error("read ack slot not released");
    AST_WORD_LOAD: assert property ((state_reg == ST_WORD ##0 byte_end_s)
        |=> addr_reg == {page_reg, $past(shift_reg)}) else $error("word address not latched");
    AST_NO_MATCH: assert property ((state_reg == ST_SLAVE ##0 byte_end_s ##0 !match)
        |=> state_reg == ST_IDLE && !sda_oe_reg) else $error("foreign address answered");
    AST_RD_NACK: assert property ((state_reg == ST_READ && ack_ph_reg && scl_fall
        && !ack_ok_reg) |=> state_reg == ST_IDLE) else $error("read went on after no ack");

endmodule

// ### test/twm_bus_master.sv
/*
 * Behavioural bus master for the two-wire memory access block.
 * Assumes the bench resolves the open-drain data wire and feeds it back.
 */
`timescale 1ns/1ps

module twm_bus_master #(
    parameter realtime HALF = 62.5
) (
    // Bus wires
    output logic      scl,
    output logic      sda_pull_low,
    input  wire logic sda_line
);
    localparam realtime Q = HALF / 2.0;

    // Clock stands high outside frames
    initial begin
        scl = 1'b1;
        sda_pull_low = 1'b0;
    end

    // ------------------------------------------------------------
    // Bit level
    // ------------------------------------------------------------
    // data set while clock low, sampled mid high
    task automatic clock_bit(input logic drive_bit, output logic seen);
        #Q sda_pull_low = !drive_bit;
        #Q scl = 1'b1;
        #Q seen = sda_line;
        #Q scl = 1'b0;
    endtask

    // start also used as repeated start
    task automatic start_cond();
        #Q sda_pull_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull_low = 1'b1;
        #Q scl = 1'b0;
    endtask

    task automatic stop_cond();
        #Q sda_pull_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull_low = 1'b0;
        #Q;
    endtask

    // ------------------------------------------------------------
    // Byte level
    // ------------------------------------------------------------
    // msb first; fewer than 8 bits leaves a partial byte
    task automatic send_bits(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            clock_bit(b[i], s);
        end
        if (n == 8) begin
            clock_bit(1'b1, s);
            ack = !s;
        end
    endtask

    // withholding the ack ends a read
    task automatic recv_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(!ack_it, s);
    endtask
endmodule

// ### test/twm_access_tb.sv
/*
 * Self-checking bench for the two-wire memory access block.
 * Assumes the bus master model drives the link; straps driven here.
 */
`timescale 1ns/1ps

module twm_access_tb;
    import twm_pkg::*;

    // Device type code; value arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h5;

    logic       clk, rst_n, scl, sda_in, sda_oe, sda_out, mst_low, cs_lo, cs_hi, wp, ack;
    logic [7:0] rd;
    int         failures = 0;
    int         num_checks = 0;

    // Wired-and data line with pull-up; the device pulls only when it drives a low
    assign sda_in = !mst_low && !(sda_oe && !sda_out);

    twm_access #(.DEV_TYPE(TYPE_CODE)) u_twm_access (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_pin_low(cs_lo), .chip_select_pin_high(cs_hi), .write_protect(wp));

    twm_bus_master u_twm_bus_master (.scl(scl), .sda_pull_low(mst_low), .sda_line(sda_in));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] slave(input logic page, input logic rd_n);
        return {TYPE_CODE, 2'b10, page, rd_n};
    endfunction

    task automatic sel(input logic [7:0] sb, input logic exp_ack);
        // Frames start off the clock edge so no pin moves as it is sampled
        @(posedge clk);
        #2;
        u_twm_bus_master.start_cond();
        u_twm_bus_master.send_bits(sb, 8, ack);
        check({7'h0, ack}, {7'h0, exp_ack}, "slave ack");
    endtask

    task automatic wbyte(input logic [7:0] b, input logic exp_ack);
        u_twm_bus_master.send_bits(b, 8, ack);
        check({7'h0, ack}, {7'h0, exp_ack}, "byte ack");
    endtask

    task automatic rbyte(input logic ack_it, input logic [7:0] exp);
        u_twm_bus_master.recv_byte(ack_it, rd);
        check(rd, exp, "read data");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_wrap();
        sel(slave(1'b1, 1'b0), 1'b1);
        wbyte(8'hfe, 1'b1);
        wbyte(8'ha1, 1'b1);
        wbyte(8'hb2, 1'b1);
        wbyte(8'hc3, 1'b1);
        u_twm_bus_master.stop_cond();
        sel(slave(1'b1, 1'b0), 1'b1);
        wbyte(8'hfe, 1'b1);
        sel(slave(1'b1, 1'b1), 1'b1);
        rbyte(1'b1, 8'ha1);
        rbyte(1'b0, 8'hb2);
        u_twm_bus_master.stop_cond();
        check({7'h0, sda_oe}, 8'h00, "released");
        sel(slave(1'b0, 1'b1), 1'b1);
        rbyte(1'b0, 8'hc3);
        u_twm_bus_master.stop_cond();
        sel(slave(1'b1, 1'b0), 1'b1);
        wbyte(8'hff, 1'b1);
        sel(slave(1'b1, 1'b1), 1'b1);
        rbyte(1'b1, 8'hb2);
        rbyte(1'b0, 8'hc3);
        u_twm_bus_master.stop_cond();
        $display("test wrap done");
    endtask

    task automatic test_protect();
        sel(slave(1'b0, 1'b0), 1'b1);
        wbyte(8'h10, 1'b1);
        wbyte(8'h5a, 1'b1);
        u_twm_bus_master.stop_cond();
        @(posedge clk) wp <= 1'b1;
        repeat (5) @(posedge clk);
        sel(slave(1'b0, 1'b0), 1'b1);
        wbyte(8'h10, 1'b1);
        wbyte(8'ha5, 1'b0);
        u_twm_bus_master.stop_cond();
        @(posedge clk) wp <= 1'b0;
        repeat (5) @(posedge clk);
        sel(slave(1'b0, 1'b1), 1'b1);
        rbyte(1'b0, 8'h5a);
        u_twm_bus_master.stop_cond();
        $display("test protect done");
    endtask

    task automatic test_abort();
        sel(slave(1'b0, 1'b0), 1'b1);
        wbyte(8'h20, 1'b1);
        wbyte(8'h11, 1'b1);
        u_twm_bus_master.stop_cond();
        sel(slave(1'b0, 1'b0), 1'b1);
        wbyte(8'h20, 1'b1);
        u_twm_bus_master.send_bits(8'hee, 7, ack);
        u_twm_bus_master.stop_cond();
        sel(slave(1'b0, 1'b0), 1'b1);
        wbyte(8'h20, 1'b1);
        u_twm_bus_master.send_bits(8'hee, 4, ack);
        sel(slave(1'b0, 1'b1), 1'b1);
        rbyte(1'b0, 8'h11);
        u_twm_bus_master.stop_cond();
        $display("test abort done");
    endtask

    task automatic test_select();
        sel({TYPE_CODE, 2'b01, 2'b00}, 1'b0);
        u_twm_bus_master.stop_cond();
        sel({~TYPE_CODE, 2'b10, 2'b00}, 1'b0);
        u_twm_bus_master.stop_cond();
        @(posedge clk) begin
            cs_hi <= 1'b0;
            cs_lo <= 1'b1;
        end
        repeat (5) @(posedge clk);
        sel({TYPE_CODE, 2'b01, 2'b00}, 1'b1);
        u_twm_bus_master.stop_cond();
        sel({TYPE_CODE, 2'b10, 2'b00}, 1'b0);
        u_twm_bus_master.stop_cond();
        $display("test select done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Roughly 40 bytes at 1.1 us each; generous margin
    initial begin
        #500us;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        cs_hi = 1'b1;
        cs_lo = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        test_wrap();
        test_protect();
        test_abort();
        test_select();
        complete_run();
    end
endmodule
